// ---- core/tmr8_timer.sv ----
// eight-bit timer top: registers, counter unit, flags, two compare channels
//
// Chosen here: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "tmr8_params.svh"

// Functional notes
// [RULE1] tick comes from io clock unless async select picks oscillator pin
// [RULE2] each tick clears, increments or decrements counter per mode; the counter here only clears or increments, never decrements
// [RULE3] clock select zero stops ticks; cpu still reads and writes counter
// [RULE4] cpu counter write beats simultaneous clear or count
// [RULE5] only waveform mode field steers the count sequence
// [RULE6] normal mode counts up only, wraps 0xFF to 0x00
// [RULE7] normal mode sets overflow flag as counter becomes zero; never clears
// [RULE8] overflow flag clears when its interrupt executes
// [RULE9] clear-on-match mode clears counter the tick after it equals compare A
// [RULE10] clear-on-match compare writes unbuffered; below count means wrap first
// [RULE11] clear-on-match raises compare A flag at top
// [RULE12] clear-on-match toggle mode flips output each match
// [RULE13] output reaches pin only while direction is output
// [RULE14] prescaler offers 1, 8, 32, 64, 128, 256, 1024
// [RULE15] clear-on-match sets overflow flag on wrap from max to zero
// [RULE16] fast pwm sets overflow flag when counter reaches top
// [RULE17] fast pwm mode two non-inverted, three inverted
// [RULE18] fast pwm top is 0xFF in mode 3, compare A in mode 7
// [RULE19] fast pwm sets at match, clears at top to bottom (inverted swaps)
// [RULE20] top at max gives 256-tick period
// [RULE21] compare bottom gives spike, compare max gives constant level
// [RULE22] fast pwm toggle mode flips on match, buffering still on
// [RULE23] compare double buffered in pwm, loaded at bottom; direct otherwise
// [RULE24] match sets flag next tick; cleared by interrupt ack or writing one
// [RULE25] counter write blocks compare matches during the next tick
// [RULE26] nonzero clock codes map to fixed taps for both sources
module tmr8_timer
	import tmr8_pkg::*;
#(
	parameter int PRE_BITS = `TMR8_PRE_BITS
) (
	input  wire logic       mclk,
	input  wire logic       rst,
	input  wire logic [3:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic      [7:0] rdata,
	input  wire logic       osc_pin_in,
	output logic            osc_pin_out,
	output logic            compare_a_output,
	output logic            compare_a_oe,
	output logic            compare_b_output,
	output logic            compare_b_oe,
	output logic            overflow_flag,
	output logic            compare_a_flag
);

	initial begin
		if (PRE_BITS < 10 || PRE_BITS > 16) $error("PRE_BITS out of range");
	end

	// ****************************************************************
	// register bus decode
	// ****************************************************************
	tmr8_bus_t bus;
	assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

	logic [7:0] timer_control_a;
	logic [7:0] timer_control_b;
	logic [7:0] counter_value;
	logic [7:0] compare_a_buf;
	logic [7:0] compare_b_buf;
	logic [7:0] compare_a_value;
	logic [7:0] compare_b_value;
	logic       compare_b_flag;
	logic       async_clock_select;
	logic [1:0] pin_dir;
	logic       block_next;

	wire w_ctrl_a = bus.wr && bus.addr == `TMR8_OFS_CTRL_A;
	wire w_ctrl_b = bus.wr && bus.addr == `TMR8_OFS_CTRL_B;
	wire w_count  = bus.wr && bus.addr == `TMR8_OFS_COUNT;
	wire w_cmp_a  = bus.wr && bus.addr == `TMR8_OFS_CMP_A;
	wire w_cmp_b  = bus.wr && bus.addr == `TMR8_OFS_CMP_B;
	wire w_flags  = bus.wr && bus.addr == `TMR8_OFS_FLAGS;
	wire w_async  = bus.wr && bus.addr == `TMR8_OFS_ASYNC;
	wire w_dir    = bus.wr && bus.addr == `TMR8_OFS_DIR;
	wire w_ack    = bus.wr && bus.addr == `TMR8_OFS_ACK;

	// ****************************************************************
	// mode decode
	// ****************************************************************
	wire [2:0] waveform_mode_field = {timer_control_b[`TMR8_B_WGM2],
	                                  timer_control_a[`TMR8_A_WGM_LO]};
	wire       mode_clr  = waveform_mode_field == `TMR8_WGM_CLR_MATCH;
	wire       mode_fast = waveform_mode_field == `TMR8_WGM_FAST_FF ||
	                       waveform_mode_field == `TMR8_WGM_FAST_OCA;
	// pwm codes are 3 and 7; other codes except clear-on-match (2) count like normal mode
	wire       pwm_mode  = mode_fast;

	// ****************************************************************
	// tick
	// ****************************************************************
	logic timer_tick;

	tmr8_prescaler #(
		.PRE_BITS (PRE_BITS)
	) u_pre (
		.mclk               (mclk),
		.rst                (rst),
		.async_clock_select (async_clock_select),
		.osc_pin_in         (osc_pin_in),
		.clock_select_field (timer_control_b[`TMR8_B_CS]),
		.timer_tick         (timer_tick)
	);

	// oscillator drive is not modelled; pin held low
	assign osc_pin_out = 1'b0;

	// ****************************************************************
	// counter unit
	// ****************************************************************
	wire [7:0] top_value = (waveform_mode_field == `TMR8_WGM_FAST_OCA || mode_clr)
	                       ? compare_a_value : `TMR8_MAX;                // see [RULE18]
	wire       at_top    = counter_value == top_value;
	// clear-on-match clears only on an unblocked a match, so a counter write skips it
	wire       clr_top   = ((mode_clr && !block_next) || mode_fast) && at_top; // see [RULE9]
	wire       at_max    = counter_value == `TMR8_MAX;

	tmr8_evt_t evt;
	assign evt.at_top  = at_top;
	assign evt.wrap    = clr_top || at_max;                              // see [RULE6]
	assign evt.match_a = counter_value == compare_a_value && !block_next; // see [RULE25]
	assign evt.match_b = counter_value == compare_b_value && !block_next;

	// up-only sequence for the modes built; field alone picks it
	wire [7:0] next_count = w_count ? bus.wdata :                        // see [RULE4]
	                        !timer_tick ? counter_value :               // see [RULE3]
	                        evt.wrap ? `TMR8_BOTTOM :                    // see [RULE2] see [RULE5]
	                        8'(counter_value + 8'h01);

	// counter write arms blocking until the next tick completes
	wire next_block = w_count ? 1'b1 : (timer_tick ? 1'b0 : block_next);

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			counter_value <= `TMR8_RST_BYTE;
			block_next    <= 1'b0;
		end else begin
			counter_value <= next_count;
			block_next    <= next_block;
		end
	end

	// ****************************************************************
	// compare registers
	// ****************************************************************
	// pwm loads the active value at bottom; other modes write through
	wire load_cmp = pwm_mode ? (timer_tick && evt.wrap) : 1'b1;          // see [RULE23]

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			compare_a_buf   <= `TMR8_RST_BYTE;
			compare_b_buf   <= `TMR8_RST_BYTE;
		end else begin
			if (w_cmp_a) compare_a_buf <= bus.wdata;
			if (w_cmp_b) compare_b_buf <= bus.wdata;
		end
	end

	wire [7:0] next_cmp_a = (!pwm_mode && w_cmp_a) ? bus.wdata :         // see [RULE10]
	                        load_cmp ? compare_a_buf : compare_a_value;
	wire [7:0] next_cmp_b = (!pwm_mode && w_cmp_b) ? bus.wdata :
	                        load_cmp ? compare_b_buf : compare_b_value;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			compare_a_value <= `TMR8_RST_BYTE;
			compare_b_value <= `TMR8_RST_BYTE;
		end else begin
			compare_a_value <= next_cmp_a;
			compare_b_value <= next_cmp_b;
		end
	end

	// ****************************************************************
	// control registers
	// ****************************************************************
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			timer_control_a    <= `TMR8_RST_BYTE;
			timer_control_b    <= `TMR8_RST_BYTE;
			async_clock_select <= 1'b0;
			pin_dir            <= 2'b00;
		end else begin
			if (w_ctrl_a) timer_control_a <= bus.wdata;
			if (w_ctrl_b) timer_control_b <= {4'h0, bus.wdata[3:0]};
			if (w_async) async_clock_select <= bus.wdata[0];
			if (w_dir) pin_dir <= bus.wdata[1:0];
		end
	end

	// ****************************************************************
	// flags
	// ****************************************************************
	// overflow: normal/ctc on wrap from max to zero, fast pwm on reaching top
	wire ovf_set = timer_tick && (mode_fast ? (counter_value == 8'(top_value - 8'h01))
	                                        : at_max);                  // see [RULE7] see [RULE15]
	// flags land with the tick after the match is seen
	wire cma_set = timer_tick && evt.match_a;                            // see [RULE11] see [RULE24]
	wire cmb_set = timer_tick && evt.match_b;
	wire ovf_clr = (w_flags && bus.wdata[`TMR8_F_OVF]) ||
	               (w_ack && bus.wdata[`TMR8_F_OVF]);                    // see [RULE8]
	wire cma_clr = (w_flags || w_ack) && bus.wdata[`TMR8_F_CMPA];
	wire cmb_clr = (w_flags || w_ack) && bus.wdata[`TMR8_F_CMPB];

	// set wins over a clear in the same cycle
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			overflow_flag  <= 1'b0;
			compare_a_flag <= 1'b0;
			compare_b_flag <= 1'b0;
		end else begin
			overflow_flag  <= ovf_set | (overflow_flag & ~ovf_clr);      // see [RULE16]
			compare_a_flag <= cma_set | (compare_a_flag & ~cma_clr);
			compare_b_flag <= cmb_set | (compare_b_flag & ~cmb_clr);
		end
	end

	// ****************************************************************
	// compare outputs
	// ****************************************************************
	// extremes fall out naturally: bottom gives a one-tick spike, max a flat level
	tmr8_wavegen u_wave_a (                                              // see [RULE20] see [RULE21]
		.mclk       (mclk),
		.rst        (rst),
		.tick       (timer_tick),
		.pwm_mode   (pwm_mode),
		.match      (evt.match_a),
		.wrap       (evt.wrap),
		.mode       (tmr8_com_t'(timer_control_a[`TMR8_A_COMA])),
		.pin_is_out (pin_dir[0]),
		.level      (),
		.pin_out    (compare_a_output),
		.pin_oe     (compare_a_oe)
	);

	tmr8_wavegen u_wave_b (
		.mclk       (mclk),
		.rst        (rst),
		.tick       (timer_tick),
		.pwm_mode   (pwm_mode),
		.match      (evt.match_b),
		.wrap       (evt.wrap),
		.mode       (tmr8_com_t'(timer_control_a[`TMR8_A_COMB])),
		.pin_is_out (pin_dir[1]),
		.level      (),
		.pin_out    (compare_b_output),
		.pin_oe     (compare_b_oe)
	);

	// ****************************************************************
	// read path
	// ****************************************************************
	// buffered values read back in pwm so software sees what it wrote
	wire [7:0] rd_mux =
		(bus.addr == `TMR8_OFS_CTRL_A) ? timer_control_a :
		(bus.addr == `TMR8_OFS_CTRL_B) ? timer_control_b :
		(bus.addr == `TMR8_OFS_COUNT)  ? counter_value :
		(bus.addr == `TMR8_OFS_CMP_A)  ? compare_a_buf :
		(bus.addr == `TMR8_OFS_CMP_B)  ? compare_b_buf :
		(bus.addr == `TMR8_OFS_FLAGS)  ? {5'h00, compare_b_flag, compare_a_flag, overflow_flag} :
		(bus.addr == `TMR8_OFS_ASYNC)  ? {7'h00, async_clock_select} :
		(bus.addr == `TMR8_OFS_DIR)    ? {6'h00, pin_dir} : 8'h00;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) rdata <= 8'h00;
		else rdata <= bus.rd ? rd_mux : 8'h00;
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	cpu_write_wins_a: assert property (@(posedge mclk) disable iff (rst) // see [RULE4]
		w_count |=> counter_value == $past(wdata))
		else $error("counter write lost");

	stopped_hold_a: assert property (@(posedge mclk) disable iff (rst) // see [RULE3]
		(timer_control_b[2:0] == 3'd0 && !w_count) |=> $stable(counter_value))
		else $error("counter moved while stopped");

	normal_wrap_a: assert property (@(posedge mclk) disable iff (rst) // see [RULE6]
		(waveform_mode_field == 3'd0 && timer_tick && counter_value == 8'hFF && !w_count)
		|=> counter_value == 8'h00 && overflow_flag)
		else $error("normal wrap wrong");

	clr_match_a: assert property (@(posedge mclk) disable iff (rst) // see [RULE9]
		(mode_clr && timer_tick && counter_value == compare_a_value && !block_next && !w_count)
		|=> counter_value == 8'h00)
		else $error("clear on match missed");

	count_step_a: assert property (@(posedge mclk) disable iff (rst) // see [RULE2]
		(timer_tick && !evt.wrap && !w_count)
		|=> counter_value == 8'($past(counter_value) + 8'h01))
		else $error("count step wrong");

	match_flag_a: assert property (@(posedge mclk) disable iff (rst) // see [RULE24]
		(timer_tick && evt.match_a) |=> compare_a_flag)
		else $error("compare flag not set");

	block_match_a: assert property (@(posedge mclk) disable iff (rst) // see [RULE25]
		(w_count && !compare_a_flag) ##1 (!timer_tick && !w_ack && !w_flags)
		|=> !compare_a_flag)
		else $error("match not blocked");

	pin_gate_a: assert property (@(posedge mclk) disable iff (rst) // see [RULE13]
		!pin_dir[0] |-> !compare_a_oe)
		else $error("pin driven as input");

	toggle_clr_a: assert property (@(posedge mclk) disable iff (rst) // see [RULE12]
		(mode_clr && timer_control_a[7:6] == 2'b01 && timer_tick && evt.match_a && !w_ctrl_a)
		|=> compare_a_output != $past(compare_a_output))
		else $error("toggle missed");

	// only software may drop the overflow flag
	ovf_hold_a: assert property (@(posedge mclk) disable iff (rst) // see [RULE7]
		(overflow_flag && !w_flags && !w_ack) |=> overflow_flag)
		else $error("overflow flag dropped by counting");

	fast_ovf_a: assert property (@(posedge mclk) disable iff (rst) // see [RULE16]
		(mode_fast && timer_tick && !w_count && 8'(counter_value + 8'h01) == top_value)
		|=> overflow_flag)
		else $error("overflow not set on reaching top");

	pwm_clear_a: assert property (@(posedge mclk) disable iff (rst) // see [RULE19]
		(mode_fast && timer_control_a[7:6] == 2'h2 && timer_tick && evt.wrap && !evt.match_a)
		|=> !compare_a_output)
		else $error("pwm output not cleared at bottom");

	pwm_buffer_a: assert property (@(posedge mclk) disable iff (rst) // see [RULE23]
		(pwm_mode && !(timer_tick && evt.wrap)) |=> $stable(compare_a_value))
		else $error("active compare changed mid period");

endmodule : tmr8_timer

`default_nettype wire

// ---- include/tmr8_params.svh ----
// constants for the eight-bit timer: offsets, fields, resets, modes
`ifndef TMR8_PARAMS_SVH
`define TMR8_PARAMS_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define TMR8_OFS_CTRL_A   4'h0
`define TMR8_OFS_CTRL_B   4'h1
`define TMR8_OFS_COUNT    4'h2
`define TMR8_OFS_CMP_A    4'h3
`define TMR8_OFS_CMP_B    4'h4
`define TMR8_OFS_FLAGS    4'h5
`define TMR8_OFS_ASYNC    4'h6
`define TMR8_OFS_DIR      4'h7
`define TMR8_OFS_ACK      4'h8

// ****************************************************************
// field positions
// ****************************************************************
`define TMR8_A_WGM_LO     1:0
`define TMR8_A_COMB       5:4
`define TMR8_A_COMA       7:6
`define TMR8_B_CS         2:0
`define TMR8_B_WGM2       3
`define TMR8_F_OVF        0
`define TMR8_F_CMPA       1
`define TMR8_F_CMPB       2

// ****************************************************************
// reset values and waveform mode codes
// ****************************************************************
`define TMR8_RST_BYTE     8'h00
`define TMR8_MAX          8'hFF
`define TMR8_BOTTOM       8'h00
`define TMR8_WGM_NORMAL   3'h0
`define TMR8_WGM_CLR_MATCH 3'h2
`define TMR8_WGM_FAST_FF  3'h3
`define TMR8_WGM_FAST_OCA 3'h7

// prescaler: ten bits reach division by 1024
`define TMR8_PRE_BITS     10

`endif

// ---- include/tmr8_pkg.sv ----
// types shared by the eight-bit timer files
package tmr8_pkg;

	// compare output mode codes
	typedef enum logic [1:0] {
		TMR8_COM_OFF    = 2'b00,
		TMR8_COM_TOGGLE = 2'b01,
		TMR8_COM_CLEAR  = 2'b10,
		TMR8_COM_SET    = 2'b11
	} tmr8_com_t;

	// register bus request
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} tmr8_bus_t;

	// counter events for one tick
	typedef struct packed {
		logic at_top;
		logic wrap;
		logic match_a;
		logic match_b;
	} tmr8_evt_t;

endpackage : tmr8_pkg

// ---- core/tmr8_prescaler.sv ----
// tick generator: source select, prescaler taps, stop on code zero
`timescale 1ns/1ps
`default_nettype none

module tmr8_prescaler
	import tmr8_pkg::*;
#(
	parameter int PRE_BITS = 10
) (
	input  wire logic       mclk,
	input  wire logic       rst,
	input  wire logic       async_clock_select,
	input  wire logic       osc_pin_in,
	input  wire logic [2:0] clock_select_field,
	output logic            timer_tick
);

	initial begin
		if (PRE_BITS < 10) $error("prescaler needs ten bits for 1024");
	end

	logic [PRE_BITS-1:0] div;
	logic                osc_q;
	wire                 osc_rise;
	wire                 src_en;
	wire  [PRE_BITS-1:0] next_div;
	wire                 tap;

	// oscillator pin taken as synchronous; one source pulse per rising edge
	assign osc_rise = osc_pin_in & ~osc_q;
	assign src_en   = async_clock_select ? osc_rise : 1'b1;
	assign next_div = src_en ? div + 1'b1 : div;

	// ****************************************************************
	// divider
	// ****************************************************************
	// one counter serves both sources, so taps match either way
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			div   <= '0;
			osc_q <= 1'b0;
		end else begin
			div   <= next_div;
			osc_q <= osc_pin_in;
		end
	end

	// tap reaches all-ones right before rollover: one pulse per period
	assign tap = (clock_select_field == 3'd1) ? 1'b1 :                  // see [RULE26]
	             (clock_select_field == 3'd2) ? &div[2:0] :             // see [RULE14]
	             (clock_select_field == 3'd3) ? &div[4:0] :
	             (clock_select_field == 3'd4) ? &div[5:0] :
	             (clock_select_field == 3'd5) ? &div[6:0] :
	             (clock_select_field == 3'd6) ? &div[7:0] :
	             (clock_select_field == 3'd7) ? &div[9:0] : 1'b0;       // see [RULE3]

	// tick only when the source advanced; code zero stops all ticks
	assign timer_tick = src_en & tap;                                    // see [RULE1]

endmodule : tmr8_prescaler

`default_nettype wire

// ---- core/tmr8_wavegen.sv ----
// compare output level generator for one channel
`timescale 1ns/1ps
`default_nettype none

module tmr8_wavegen
	import tmr8_pkg::*;
(
	input  wire logic      mclk,
	input  wire logic      rst,
	input  wire logic      tick,
	input  wire logic      pwm_mode,
	input  wire logic      match,
	input  wire logic      wrap,
	input  wire tmr8_com_t mode,
	input  wire logic      pin_is_out,
	output logic           level,
	output logic           pin_out,
	output logic           pin_oe
);

	logic next_level;

	// next level per mode; match wins over the wrap reset in pwm
	always_comb begin
		next_level = level;
		if (tick) begin
			unique case (mode)
				TMR8_COM_OFF: next_level = level;
				TMR8_COM_TOGGLE: begin
					if (match) next_level = ~level;                      // see [RULE12] see [RULE22]
				end
				TMR8_COM_CLEAR: begin
					if (pwm_mode && match) next_level = 1'b1;           // see [RULE17] see [RULE19]
					else if (pwm_mode && wrap) next_level = 1'b0;
					else if (match) next_level = 1'b0;
				end
				TMR8_COM_SET: begin
					if (pwm_mode && match) next_level = 1'b0;           // see [RULE19]
					else if (pwm_mode && wrap) next_level = 1'b1;
					else if (match) next_level = 1'b1;
				end
			endcase
		end
	end

	// ****************************************************************
	// output register
	// ****************************************************************
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) level <= 1'b0;
		else level <= next_level;
	end

	// pin shows the level only while set as output
	assign pin_oe  = pin_is_out & (mode != TMR8_COM_OFF);               // see [RULE13]
	assign pin_out = level;

endmodule : tmr8_wavegen

`default_nettype wire

// ---- tb/tmr8_testbench.sv ----
// self-checking bench for the eight-bit timer, driven over its register port
`timescale 1ns/1ps
`default_nettype none
`include "tmr8_params.svh"

module testbench
	import tmr8_pkg::*;
;
	logic       mclk;
	logic       rst;
	logic [3:0] addr;
	logic [7:0] wdata;
	logic       wr;
	logic       rd;
	logic [7:0] rdata;
	logic       osc_pin_in;
	logic       oca;
	logic       oca_oe;
	logic       ocb;
	logic       ocb_oe;
	logic       ovf;
	logic       cfa;
	int         failures;
	int         check_count;
	int         cyc;
	int         fac [7] = '{1, 8, 32, 64, 128, 256, 1024};

	tmr8_timer u_dut (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .osc_pin_in(osc_pin_in), .osc_pin_out(), .compare_a_output(oca),
		.compare_a_oe(oca_oe), .compare_b_output(ocb), .compare_b_oe(ocb_oe),
		.overflow_flag(ovf), .compare_a_flag(cfa));

	// ****************************************************************
	// clocks and run limit
	// ****************************************************************
	// clock, plus an oscillator whose edges never meet the clock edge
	always #5 mclk = ~mclk;
	initial begin
		osc_pin_in = 1'b0;
		#2;
		forever #35 osc_pin_in = ~osc_pin_in;
	end

	// ceiling well above the slowest prescaler sweep
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			failures++;
			conclude();
		end
	end

	// ****************************************************************
	// bus tasks and comparison
	// ****************************************************************
	task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge mclk);
		wr    <= 1'b0;
	endtask : bus_wr

	task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// read data stand only in the cycle after the strobe
	task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
		@(posedge mclk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge mclk);
		rd   <= 1'b0;
		#1;
		chk($sformatf("register %0d", a), {8'h00, rdata}, {8'h00, e});
	endtask : rd_chk

	task automatic cycles(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : cycles

	task automatic wait_lvl(input logic ch, input logic lvl);
		int n;
		n = 0;
		while (((ch ? ocb : oca) !== lvl) && n < 5000) begin
			cycles(1);
			n++;
		end
	endtask : wait_lvl

	// length of one stretch at a level, in clock cycles
	task automatic span(input logic ch, input logic lvl, input int exp);
		int t0;
		wait_lvl(ch, !lvl);
		wait_lvl(ch, lvl);
		t0 = cyc;
		wait_lvl(ch, !lvl);
		chk("level span", 16'(cyc - t0), exp[15:0]);
	endtask : span

	// stop the timer and load mode, compares and counter directly
	task automatic setup(input logic [7:0] ca, input logic [7:0] cb, input logic [7:0] cnt);
		bus_wr(`TMR8_OFS_CTRL_B, 8'h00);
		bus_wr(`TMR8_OFS_CTRL_A, 8'h00);
		bus_wr(`TMR8_OFS_CMP_A, ca);
		bus_wr(`TMR8_OFS_CMP_B, cb);
		bus_wr(`TMR8_OFS_COUNT, cnt);
		bus_wr(`TMR8_OFS_FLAGS, 8'h07);
	endtask : setup

	// late compare: expected match lies beyond a full wrap
	task automatic late_match(input logic [7:0] cnt, input logic [7:0] ca);
		setup(ca, 8'h00, cnt);
		bus_wr(`TMR8_OFS_CTRL_A, 8'h02);
		bus_wr(`TMR8_OFS_CTRL_B, 8'h01);
		cycles(100);
		chk("compare flag early", {15'h0, cfa}, 16'h0000);
		cycles(200);
		chk("compare flag late", {15'h0, cfa}, 16'h0001);
		chk("overflow on wrap", {15'h0, ovf}, 16'h0001);
		// compare b sits at zero, so the wrap sets its flag too
		rd_chk(`TMR8_OFS_FLAGS, 8'h07);
	endtask : late_match

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : conclude

	// ****************************************************************
	// test sequence
	// ****************************************************************
	initial begin
		mclk = 1'b0;
		rst = 1'b1;
		addr = 4'h0;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		failures = 0;
		check_count = 0;
		cyc = 0;
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		chk("outputs after reset", {12'h000, oca, ocb, ovf, cfa}, 16'h0000);
		for (int a = 0; a < 10; a++) rd_chk(4'(a), 8'h00);
		bus_wr(4'h9, 8'hA5);
		rd_chk(4'h9, 8'h00);
		$display("done: reset and map");
		// stopped counter still written and read
		bus_wr(`TMR8_OFS_COUNT, 8'h5A);
		cycles(20);
		rd_chk(`TMR8_OFS_COUNT, 8'h5A);
		$display("done: stopped counter");
		// normal mode, output mode bits set to show they do not steer counting
		setup(8'h08, 8'h00, 8'hF0);
		bus_wr(`TMR8_OFS_CTRL_A, 8'hC0);
		bus_wr(`TMR8_OFS_CTRL_B, 8'h01);
		cycles(12);
		chk("overflow before wrap", {15'h0, ovf}, 16'h0000);
		cycles(8);
		chk("overflow at wrap", {15'h0, ovf}, 16'h0001);
		cycles(300);
		chk("overflow held", {15'h0, ovf}, 16'h0001);
		bus_wr(`TMR8_OFS_ACK, 8'h01);
		#1;
		chk("overflow after ack", {15'h0, ovf}, 16'h0000);
		bus_wr(`TMR8_OFS_FLAGS, 8'h02);
		#1;
		chk("compare flag write one", {15'h0, cfa}, 16'h0000);
		$display("done: normal mode");
		late_match(8'h50, 8'h10);
		late_match(8'h20, 8'h20);
		$display("done: late and blocked match");
		// toggle output in clear-on-match mode, pin gated by direction
		setup(8'h09, 8'h00, 8'h00);
		bus_wr(`TMR8_OFS_CTRL_A, {TMR8_COM_TOGGLE, 4'h0, 2'b10});
		bus_wr(`TMR8_OFS_DIR, 8'h01);
		bus_wr(`TMR8_OFS_CTRL_B, 8'h01);
		span(1'b0, 1'b1, 10);
		chk("compare flag at top", {15'h0, cfa}, 16'h0001);
		chk("pin enabled", {15'h0, oca_oe}, 16'h0001);
		bus_wr(`TMR8_OFS_DIR, 8'h00);
		#1;
		chk("pin released", {15'h0, oca_oe}, 16'h0000);
		// every prescaler code, compare zero toggles once per tick
		setup(8'h00, 8'h00, 8'h00);
		bus_wr(`TMR8_OFS_CTRL_A, 8'h42);
		for (int i = 0; i < 7; i++) begin
			bus_wr(`TMR8_OFS_CTRL_B, 8'(i + 1));
			span(1'b0, 1'b1, fac[i]);
		end
		// oscillator source: one tick per oscillator rising edge
		bus_wr(`TMR8_OFS_ASYNC, 8'h01);
		bus_wr(`TMR8_OFS_CTRL_B, 8'h01);
		span(1'b0, 1'b1, 7);
		bus_wr(`TMR8_OFS_ASYNC, 8'h00);
		$display("done: clear-on-match and clock sources");
		// fast pwm with top at max, both polarities
		setup(8'h40, 8'h00, 8'h00);
		bus_wr(`TMR8_OFS_CTRL_A, 8'hA3);
		bus_wr(`TMR8_OFS_CTRL_B, 8'h01);
		// high from the match tick to the top tick, low for compare plus one
		span(1'b0, 1'b1, 191);
		span(1'b0, 1'b0, 65);
		chk("overflow at top", {15'h0, ovf}, 16'h0001);
		bus_wr(`TMR8_OFS_CTRL_A, 8'hE3);
		span(1'b0, 1'b0, 191);
		// fast pwm with top from compare a, channel b non-inverted
		setup(8'h09, 8'h02, 8'h00);
		bus_wr(`TMR8_OFS_CTRL_A, 8'h23);
		bus_wr(`TMR8_OFS_CTRL_B, 8'h09);
		span(1'b1, 1'b1, 7);
		span(1'b1, 1'b0, 3);
		// fast pwm toggle on channel a, match once per period
		setup(8'h04, 8'h00, 8'h00);
		bus_wr(`TMR8_OFS_CTRL_A, 8'h43);
		bus_wr(`TMR8_OFS_CTRL_B, 8'h09);
		span(1'b0, 1'b1, 5);
		rd_chk(`TMR8_OFS_CMP_A, 8'h04);
		$display("done: fast pwm");
		conclude();
	end
endmodule : testbench

`default_nettype wire
